// File: design/sec_command_port.sv
// command, status and array logic of a three-wire serial eeprom
`timescale 1ns/1ps
`include "sec_params.svh"

// Function
// - select high selects, low deselects to standby
// - running program cycle finishes despite select
// - select low resets partial instruction decoding
// - bits sampled and read data launched rising
// - serial clock may pause at either level
// - before start bit, clocks change nothing
// - exact clock count, then ignore until start
// - program cycle needs no serial clock
// - read data driven with serial clock
// - status shown when select raised after launch
// - no status if select low throughout
// - output off except read data or status
// - status low while busy, high when ready
// - output off on falling select
// - program within 6 ms; write-all within 15 ms
// - start at first rise with select, input high
// - programming disabled after reset until enabled
// - read gives leading zero, then sequential words
// - falling select launches program cycle
module sec_command_port #(
  parameter int ORG_X16 = 0,
  parameter int PROG_CYCLES = `SEC_WRITE_TIME_NS / `SEC_CLK_PERIOD_NS,
  parameter int ERASE_ALL_CMD_CYCLES = `SEC_ERASE_ALL_TIME_NS / `SEC_CLK_PERIOD_NS,
  parameter int WRITE_ALL_CMD_CYCLES = `SEC_WRITE_ALL_TIME_NS / `SEC_CLK_PERIOD_NS,
  parameter int FIFO_DEPTH = `SEC_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // serial pins from the controller
  input wire logic select_i,
  input wire logic sclk_i,
  input wire logic serial_in_i,
  // serial output pin, two signals: value and enable
  output logic serial_out_o,
  output logic serial_out_oe_o,
  // state seen by the system
  output logic program_enabled_o,
  output logic busy_o
);
  import sec_pkg::*;

  // ***********************************************
  // sizes
  // ***********************************************
  localparam int DW = (ORG_X16 != 0) ? 16 : 8; // data bits per word
  localparam int AW = (ORG_X16 != 0) ? 8 : 9; // address bits
  localparam int WORDS = 1 << AW; // array entries
  localparam int HW = `SEC_OPC_BITS + AW; // header bits after start_bit

  // ***********************************************
  // pin sampling and edges
  // ***********************************************
  logic [2:0] pins; // synchronised {select, sclk, serial_in}
  logic sel; // select, synchronised
  logic sclk; // serial clock, synchronised
  logic din; // serial_in, synchronised
  logic sclk_d; // previous sclk for edge find
  logic sel_d; // previous select
  logic rise; // one-cycle pulse per rising serial clock
  logic sel_fall; // one-cycle pulse when select drops

  sec_pin_sync #(
    .W(3)
  ) u_pin_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .pin_i({select_i, sclk_i, serial_in_i}),
    .pin_o(pins)
  );

  assign sel = pins[2];
  assign sclk = pins[1];
  assign din = pins[0];

  // edge finder; only edges move the frame, so a paused clock holds state
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sclk_d <= 1'b0;
      sel_d <= 1'b0;
    end else begin
      sclk_d <= sclk;
      sel_d <= sel;
    end
  end

  assign rise = sclk && !sclk_d;
  assign sel_fall = sel_d && !sel;

  // ***********************************************
  // frame state
  // ***********************************************
  sec_state_type state; // frame state
  sec_prog_type kind; // pending or running program kind
  logic [4:0] bit_cnt; // bits taken in the current field
  logic [HW-1:0] hdr; // opcode and address shift
  logic [AW-1:0] addr; // latched address
  logic [DW-1:0] wdata; // write data shift
  logic prog_en; // programming allowed
  logic [23:0] prog_cnt; // program cycle timer
  logic [23:0] prog_last; // last count of the running cycle
  logic status_req; // a program cycle was launched, status owed

  // header decode, seen as the last header bit arrives
  logic [HW-1:0] next_hdr; // header including the bit now sampled
  logic [1:0] opc; // opcode field
  logic [1:0] sub; // special command field
  logic [AW-1:0] hadr; // address field
  logic start_seen; // start_bit taken this cycle
  logic hdr_last; // last header bit taken this cycle
  logic data_last; // last data bit taken this cycle
  logic busy_done; // last cycle of the program timer

  assign next_hdr = {hdr[HW-2:0], din};
  assign opc = next_hdr[HW-1:AW];
  assign hadr = next_hdr[AW-1:0];
  assign sub = next_hdr[AW-1:AW-2];
  assign start_seen = (state == SEC_IDLE) && sel && rise && din;
  assign hdr_last = (state == SEC_HDR) && sel && rise && (bit_cnt == 5'(HW - 1));
  assign data_last = (state == SEC_DATA) && sel && rise && (bit_cnt == 5'(DW - 1));
  assign busy_done = (state == SEC_BUSY) && (prog_cnt == prog_last);

  // cycle limit per kind
  always_comb begin
    case (kind)
      SEC_PG_WRITE_ALL: prog_last = 24'(WRITE_ALL_CMD_CYCLES - 1);
      SEC_PG_ERASE_ALL: prog_last = 24'(ERASE_ALL_CMD_CYCLES - 1);
      default: prog_last = 24'(PROG_CYCLES - 1);
    endcase
  end

  // frame sequencer; select low clears it except when armed (it launches the cycle) or programming
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state <= SEC_IDLE;
      bit_cnt <= 5'h00;
    end else begin
      case (state)
        // waiting: clocks without a start_bit do nothing
        SEC_IDLE: begin
          if (start_seen) begin
            state <= SEC_HDR;
            bit_cnt <= 5'h00;
          end
        end
        // opcode and address bits
        SEC_HDR: begin
          if (!sel) begin
            state <= SEC_IDLE;
          end else if (rise) begin
            bit_cnt <= bit_cnt + 5'h01;
            if (hdr_last) begin
              bit_cnt <= 5'h00;
              case (opc)
                `SEC_OPC_READ: state <= SEC_READ;
                `SEC_OPC_WRITE: state <= SEC_DATA;
                `SEC_OPC_ERASE: state <= prog_en ? SEC_ARMED : SEC_DONE;
                default: begin
                  // special commands chosen by the top address bits
                  if (sub == `SEC_SUB_WRITE_ALL) begin
                    state <= SEC_DATA;
                  end else if (sub == `SEC_SUB_ERASE_ALL && prog_en) begin
                    state <= SEC_ARMED;
                  end else begin
                    state <= SEC_DONE;
                  end
                end
              endcase
            end
          end
        end
        // write data bits
        SEC_DATA: begin
          if (!sel) begin
            state <= SEC_IDLE;
          end else if (rise) begin
            bit_cnt <= bit_cnt + 5'h01;
            if (data_last) begin
              state <= prog_en ? SEC_ARMED : SEC_DONE;
            end
          end
        end
        // complete frame: falling select starts the cycle
        SEC_ARMED: begin
          if (sel_fall) begin
            state <= SEC_BUSY;
          end
        end
        // self-timed; neither select nor clock matters here
        SEC_BUSY: begin
          if (busy_done) begin
            state <= SEC_IDLE;
          end
        end
        // streaming read and finished frames end with select
        SEC_READ, SEC_DONE: begin
          if (!sel) begin
            state <= SEC_IDLE;
          end
        end
        default: state <= SEC_IDLE;
      endcase
    end
  end

  // header, address and data shifts
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      hdr <= '0;
      addr <= '0;
      wdata <= '0;
      kind <= SEC_PG_ERASE;
    end else if ((state == SEC_HDR) && sel && rise) begin
      hdr <= next_hdr;
      if (hdr_last) begin
        addr <= hadr;
        case (opc)
          `SEC_OPC_WRITE: kind <= SEC_PG_WRITE;
          `SEC_OPC_ERASE: kind <= SEC_PG_ERASE;
          `SEC_OPC_SPECIAL: kind <= (sub == `SEC_SUB_WRITE_ALL) ? SEC_PG_WRITE_ALL : SEC_PG_ERASE_ALL;
          default: kind <= kind;
        endcase
      end
    end else if ((state == SEC_DATA) && sel && rise) begin
      wdata <= {wdata[DW-2:0], din};
    end
  end

  // programming permission; clear after reset as after power-up
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      prog_en <= 1'b0;
    end else if (hdr_last && opc == `SEC_OPC_SPECIAL) begin
      if (sub == `SEC_SUB_ENABLE) begin
        prog_en <= 1'b1;
      end else if (sub == `SEC_SUB_DISABLE) begin
        prog_en <= 1'b0;
      end
    end
  end

  // program timer, counts on the system clock only
  always_ff @(posedge clk_i) begin
    if (srst_i || state != SEC_BUSY) begin
      prog_cnt <= 24'h000000;
    end else begin
      prog_cnt <= prog_cnt + 24'h000001;
    end
  end

  // status owed from launch until the next start_bit
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      status_req <= 1'b0;
    end else if ((state == SEC_ARMED) && sel_fall) begin
      status_req <= 1'b1;
    end else if (start_seen) begin
      status_req <= 1'b0;
    end
  end

  // ***********************************************
  // array, one generate branch per entry
  // ***********************************************
  logic [DW-1:0] mem [WORDS]; // storage, erased after reset

  // erase sets ones; write-all covers its own erase by overwriting
  for (genvar gi = 0; gi < WORDS; gi++) begin : g_entry
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        mem[gi] <= '1;
      end else if (busy_done && (kind[1] || addr == AW'(gi))) begin
        mem[gi] <= kind[0] ? wdata : '1;
      end
    end
  end

  // ***********************************************
  // read prefetch through the fifo
  // ***********************************************
  logic pf_on; // prefetch running
  logic [AW-1:0] pf_addr; // next address to fetch
  logic pf_ready; // fifo has room
  logic rd_valid; // fifo head valid
  logic [DW-1:0] rd_word; // fifo head
  logic pop; // serializer takes a word
  logic [4:0] rd_cnt; // bits left in the current word
  logic [DW-1:0] rd_shift; // outgoing word

  assign pop = (state == SEC_READ) && sel && rise && (rd_cnt == 5'h00);

  // fetcher stalls when the fifo is full; fifo depth hides array latency
  always_ff @(posedge clk_i) begin
    if (srst_i || !sel) begin
      pf_on <= 1'b0;
      pf_addr <= '0;
    end else if (hdr_last && opc == `SEC_OPC_READ) begin
      pf_on <= 1'b1;
      pf_addr <= hadr;
    end else if (pf_on && pf_ready) begin
      pf_addr <= pf_addr + 1'b1;
    end
  end

  sec_fifo #(
    .W(DW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .clear_i(!sel),
    .in_valid_i(pf_on),
    .in_ready_o(pf_ready),
    .in_data_i(mem[pf_addr]),
    .out_valid_o(rd_valid),
    .out_ready_i(pop),
    .out_data_o(rd_word)
  );

  // serializer, one bit per rising serial clock
  always_ff @(posedge clk_i) begin
    if (srst_i || state != SEC_READ) begin
      rd_cnt <= 5'h00;
      rd_shift <= '0;
    end else if (sel && rise) begin
      if (rd_cnt == 5'h00) begin
        rd_shift <= {rd_word[DW-2:0], 1'b0};
        rd_cnt <= 5'(DW - 1);
      end else begin
        rd_shift <= {rd_shift[DW-2:0], 1'b0};
        rd_cnt <= rd_cnt - 5'h01;
      end
    end
  end

  // ***********************************************
  // serial output pin
  // ***********************************************
  // driven only for read data or status; an empty fifo head gives a zero first bit, the rest of its word comes from the stale head
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      serial_out_o <= 1'b0;
      serial_out_oe_o <= 1'b0;
    end else if (!sel) begin
      serial_out_oe_o <= 1'b0;
    end else if (hdr_last && opc == `SEC_OPC_READ) begin
      serial_out_o <= 1'b0;
      serial_out_oe_o <= 1'b1;
    end else if (pop) begin
      serial_out_o <= rd_valid && rd_word[DW-1];
      serial_out_oe_o <= 1'b1;
    end else if ((state == SEC_READ) && rise) begin
      serial_out_o <= rd_shift[DW-1];
      serial_out_oe_o <= 1'b1;
    end else if (status_req) begin
      serial_out_o <= (state != SEC_BUSY);
      serial_out_oe_o <= 1'b1;
    end else if (state != SEC_READ) begin
      serial_out_oe_o <= 1'b0;
    end
  end

  // system-visible flags
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      program_enabled_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      program_enabled_o <= prog_en;
      busy_o <= (state == SEC_BUSY);
    end
  end

endmodule : sec_command_port

// File: design/sec_params.svh
// constants of the serial eeprom command port: timing, opcodes and sub-codes
`ifndef SEC_PARAMS_SVH
`define SEC_PARAMS_SVH

// ***********************************************
// timing
// ***********************************************
// system clock period in ns
`define SEC_CLK_PERIOD_NS 10
// longest single erase or write cycle, ns
`define SEC_WRITE_TIME_NS 6000000
// longest erase_all_time, ns
`define SEC_ERASE_ALL_TIME_NS 6000000
// longest write_all_time, ns
`define SEC_WRITE_ALL_TIME_NS 15000000
// least select_low_min_time the controller keeps, ns
`define SEC_SELECT_LOW_MIN_TIME_NS 250

// ***********************************************
// frame encodings
// ***********************************************
// two-bit opcodes after the start_bit
`define SEC_OPC_SPECIAL 2'h0
`define SEC_OPC_WRITE 2'h1
`define SEC_OPC_READ 2'h2
`define SEC_OPC_ERASE 2'h3
// special commands from the top two address bits
`define SEC_SUB_DISABLE 2'h0
`define SEC_SUB_WRITE_ALL 2'h1
`define SEC_SUB_ERASE_ALL 2'h2
`define SEC_SUB_ENABLE 2'h3
// bits after the start_bit: opcode width
`define SEC_OPC_BITS 2
// prefetch buffer depth
`define SEC_FIFO_DEPTH 8

`endif

// File: design/sec_pkg.sv
// types shared by the serial eeprom command port
package sec_pkg;

  // ***********************************************
  // frame states, gray coded along the usual path
  // ***********************************************
  typedef enum logic [2:0] {
    SEC_IDLE  = 3'h0, // selected or not, waiting for start_bit
    SEC_HDR   = 3'h1, // taking opcode and address
    SEC_DATA  = 3'h3, // taking write data
    SEC_ARMED = 3'h2, // frame complete, waiting for select to fall
    SEC_BUSY  = 3'h6, // self-timed programming cycle
    SEC_READ  = 3'h7, // streaming read data
    SEC_DONE  = 3'h5  // frame over, clock and data ignored
  } sec_state_type;

  // kind of programming cycle
  typedef enum logic [1:0] {
    SEC_PG_ERASE     = 2'h0,
    SEC_PG_WRITE     = 2'h1,
    SEC_PG_ERASE_ALL = 2'h2,
    SEC_PG_WRITE_ALL = 2'h3
  } sec_prog_type;

endpackage : sec_pkg

// File: design/sec_pin_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps

module sec_pin_sync #(
  parameter int W = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // pins and their synchronised copies
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] pin_o
);

  // ***********************************************
  // two stages
  // ***********************************************
  logic [W-1:0] meta; // first stage, read only by the second

  // each bit is its own level; bits may skew by one cycle against each other
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta <= '0;
      pin_o <= '0;
    end else begin
      meta <= pin_i;
      pin_o <= meta;
    end
  end

endmodule : sec_pin_sync

// File: design/sec_fifo.sv
// small flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps

module sec_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // flush, wins over push and pop
  input wire logic clear_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);

  // ***********************************************
  // storage and pointers
  // ***********************************************
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH]; // entries
  logic [PW:0] wr_ptr; // extra bit tells full from empty
  logic [PW:0] rd_ptr;
  logic push;
  logic pop;

  assign in_ready_o = (wr_ptr ^ rd_ptr) != {1'b1, {PW{1'b0}}};
  assign out_valid_o = wr_ptr != rd_ptr;
  assign out_data_o = mem[rd_ptr[PW-1:0]];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // write pointer
  always_ff @(posedge clk_i) begin
    if (srst_i || clear_i) begin
      wr_ptr <= '0;
    end else if (push) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  // read pointer
  always_ff @(posedge clk_i) begin
    if (srst_i || clear_i) begin
      rd_ptr <= '0;
    end else if (pop) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // entry store; contents need no reset, pointers guard them
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr[PW-1:0]] <= in_data_i;
    end
  end

endmodule : sec_fifo

// File: testbench/sec_command_port_properties.sv
// pin-level checks of the serial eeprom command port
`timescale 1ns/1ps

module sec_command_port_properties #(
  parameter int WRITE_ALL_CMD_CYCLES = 1500000
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // serial pins
  input wire logic select_i,
  input wire logic sclk_i,
  input wire logic serial_in_i,
  input wire logic serial_out_o,
  input wire logic serial_out_oe_o,
  // status
  input wire logic program_enabled_o,
  input wire logic busy_o
);
  // ********
  // helpers
  // ********
  int busy_cnt; // length of the running program cycle so far

  // counter lets the longest cycle be bounded without a huge repetition
  always_ff @(posedge clk_i) begin
    if (srst_i || !busy_o) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy_cnt + 1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  // ********
  // checks
  // ********
  deselect_oe_off_a: assert property ($fell(select_i) |-> ##[1:6] !serial_out_oe_o)
    else $error("output still driven after select fell");
  idle_oe_off_a: assert property (!select_i [*6] |-> !serial_out_oe_o)
    else $error("output driven while deselected");
  busy_status_low_a: assert property (busy_o && $past(busy_o, 2) && serial_out_oe_o && $past(serial_out_oe_o) |-> !serial_out_o)
    else $error("status high while busy");
  busy_bounded_a: assert property (busy_o |-> busy_cnt < WRITE_ALL_CMD_CYCLES)
    else $error("program cycle too long");
  busy_enabled_a: assert property ($rose(busy_o) |-> $past(program_enabled_o))
    else $error("program cycle while disabled");
  busy_selfrun_a: assert property ($rose(busy_o) |-> busy_o [*8])
    else $error("program cycle stopped early");
  busy_launch_a: assert property ($rose(busy_o) |-> !$past(select_i))
    else $error("program cycle launched while selected");
  status_shown_a: assert property ($rose(select_i) && busy_o |-> ##[1:6] serial_out_oe_o)
    else $error("no status after select rose");

  // main scenarios
  cover property ($rose(busy_o));
  cover property (serial_out_oe_o && !busy_o && serial_out_o);
  cover property ($fell(program_enabled_o));
  cover property (select_i && serial_in_i && $rose(sclk_i));
  cover property ($rose(sclk_i) && serial_out_oe_o && !busy_o);
endmodule : sec_command_port_properties

bind sec_command_port sec_command_port_properties #(
  .WRITE_ALL_CMD_CYCLES(WRITE_ALL_CMD_CYCLES)
) i_props (
  .clk_i(clk_i),
  .srst_i(srst_i),
  .select_i(select_i),
  .sclk_i(sclk_i),
  .serial_in_i(serial_in_i),
  .serial_out_o(serial_out_o),
  .serial_out_oe_o(serial_out_oe_o),
  .program_enabled_o(program_enabled_o),
  .busy_o(busy_o)
);

// File: testbench/sec_ctrl_model.sv
// model of the external controller driving the three serial pins
`timescale 1ns/1ps

module sec_ctrl_model (
  // system clock, used only to time pin changes
  input wire logic clk_i,
  // pins towards the device
  output logic select_o,
  output logic sclk_o,
  output logic serial_in_o,
  // device output and its enable
  input wire logic serial_out_i,
  input wire logic serial_out_oe_i
);
  logic phase; // alternates low phase 6/7 cycles, mean link period 125 ns

  // pins idle deselected with the link clock standing low
  initial begin
    select_o = 1'b0;
    sclk_o = 1'b0;
    serial_in_o = 1'b0;
    phase = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wait_clk

  // raise select and give the synchroniser time to see it
  task automatic open_frame();
    select_o <= 1'b1;
    wait_clk(3);
  endtask : open_frame

  // drop select, stop the clock and keep select low long enough
  task automatic close_frame();
    wait_clk(2);
    sclk_o <= 1'b0;
    select_o <= 1'b0;
    serial_in_o <= ~serial_in_o; // released line must not keep its last value
    wait_clk(30);
  endtask : close_frame

  // n bits msb first; output sampled late in the high phase, z when off
  task automatic clock_bits(input int n, input logic [31:0] value, output logic [31:0] seen);
    seen = '0;
    for (int i = n - 1; i >= 0; i--) begin
      sclk_o <= 1'b0;
      serial_in_o <= value[i];
      phase = ~phase;
      wait_clk(phase ? 7 : 6);
      sclk_o <= 1'b1;
      wait_clk(6);
      seen[i] = serial_out_oe_i ? serial_out_i : 1'bz;
    end
  endtask : clock_bits
endmodule : sec_ctrl_model

// File: testbench/sec_command_port_tb_top.sv
// self-checking bench of the serial eeprom command port, byte organisation
`timescale 1ns/1ps

module sec_command_port_tb_top;
  import sec_pkg::*;
  localparam int PROG = 400; // shortened program cycle
  localparam int WRITE_ALL_CMD = 1000; // shortened write-all cycle
  logic clk_i;
  logic srst_i;
  logic select_i;
  logic sclk_i;
  logic serial_in_i;
  logic serial_out_o;
  logic serial_out_oe_o;
  logic program_enabled_o;
  logic busy_o;
  int mismatches;
  int n_compared;
  logic [31:0] seen; // bits sampled on the serial output

  // ********
  // clock and instances
  // ********
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  sec_command_port #(.PROG_CYCLES(PROG), .ERASE_ALL_CMD_CYCLES(PROG),
    .WRITE_ALL_CMD_CYCLES(WRITE_ALL_CMD)) i_dut (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .select_i(select_i),
    .sclk_i(sclk_i),
    .serial_in_i(serial_in_i),
    .serial_out_o(serial_out_o),
    .serial_out_oe_o(serial_out_oe_o),
    .program_enabled_o(program_enabled_o),
    .busy_o(busy_o)
  );

  sec_ctrl_model i_ctrl (
    .clk_i(clk_i),
    .select_o(select_i),
    .sclk_o(sclk_i),
    .serial_in_o(serial_in_i),
    .serial_out_i(serial_out_o),
    .serial_out_oe_i(serial_out_oe_o)
  );

  // ********
  // compare and frame helpers
  // ********
  task automatic check_bit(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check_byte

  // a whole frame with exactly the bits it needs
  task automatic cmd(input int n, input logic [31:0] value);
    i_ctrl.open_frame();
    i_ctrl.clock_bits(n, value, seen);
    i_ctrl.close_frame();
  endtask : cmd

  // bounded wait for the end of a program cycle
  task automatic wait_ready(input int limit);
    check_bit("busy started", 1'b1, busy_o);
    for (int i = 0; i < limit && busy_o !== 1'b0; i++) i_ctrl.wait_clk(1);
    check_bit("busy cleared in time", 1'b0, busy_o);
  endtask : wait_ready

  // read two words with the link clock paused after the header, before the first word
  task automatic read_check(input logic [8:0] addr, input logic [7:0] exp_a, input logic [7:0] exp_b);
    i_ctrl.open_frame();
    i_ctrl.clock_bits(12, {20'h0, 3'b110, addr}, seen);
    check_bit("read dummy bit", 1'b0, seen[0]);
    i_ctrl.wait_clk(40);
    i_ctrl.clock_bits(8, 32'h0, seen);
    check_byte("read word", exp_a, seen[7:0]);
    i_ctrl.clock_bits(8, 32'h0, seen);
    check_byte("sequential word", exp_b, seen[7:0]);
    i_ctrl.close_frame();
  endtask : read_check

  // ********
  // scenarios
  // ********
  task automatic s_refused_write();
    check_bit("enabled after reset", 1'b0, program_enabled_o);
    i_ctrl.open_frame();
    i_ctrl.clock_bits(6, 32'h0, seen);
    check_bit("output before start", 1'bz, seen[0]);
    i_ctrl.clock_bits(20, {12'h0, 3'b101, 9'h005, 8'h00}, seen);
    i_ctrl.close_frame();
    check_bit("busy when disabled", 1'b0, busy_o);
    read_check(9'h005, 8'hFF, 8'hFF);
  endtask : s_refused_write

  task automatic s_write_poll();
    cmd(12, {20'h0, 3'b100, 2'b11, 7'h0});
    check_bit("enable output off", 1'bz, seen[0]);
    check_bit("enabled", 1'b1, program_enabled_o);
    cmd(20, {12'h0, 3'b101, 9'h005, 8'hA5});
    i_ctrl.open_frame();
    i_ctrl.clock_bits(12, {20'h0, 3'b110, 9'h000}, seen);
    check_byte("status while busy", 8'h00, seen[7:0]);
    wait_ready(PROG);
    i_ctrl.wait_clk(8);
    check_bit("status ready", 1'b1, serial_out_o);
    i_ctrl.close_frame();
    check_bit("off after deselect", 1'b0, serial_out_oe_o);
    read_check(9'h005, 8'hA5, 8'hFF);
  endtask : s_write_poll

  task automatic s_abort();
    i_ctrl.open_frame();
    i_ctrl.clock_bits(6, 32'h38, seen);
    i_ctrl.close_frame();
    cmd(6, 32'h05);
    read_check(9'h005, 8'hA5, 8'hFF);
  endtask : s_abort

  task automatic s_erase_quiet();
    cmd(12, {20'h0, 3'b111, 9'h005});
    i_ctrl.wait_clk(100);
    check_bit("no status while low", 1'b0, serial_out_oe_o);
    wait_ready(PROG);
    i_ctrl.open_frame();
    i_ctrl.wait_clk(8);
    check_bit("status after cycle", 1'b1, serial_out_oe_o);
    check_bit("ready after cycle", 1'b1, serial_out_o);
    i_ctrl.close_frame();
    read_check(9'h005, 8'hFF, 8'hFF);
  endtask : s_erase_quiet

  task automatic s_all_and_disable();
    cmd(20, {12'h0, 3'b100, 2'b01, 7'h0, 8'h3C});
    wait_ready(WRITE_ALL_CMD);
    read_check(9'h1FF, 8'h3C, 8'h3C);
    cmd(12, {20'h0, 3'b100, 2'b10, 7'h0});
    wait_ready(PROG);
    read_check(9'h000, 8'hFF, 8'hFF);
    cmd(12, {20'h0, 3'b100, 2'b00, 7'h0});
    check_bit("disabled", 1'b0, program_enabled_o);
    cmd(12, {20'h0, 3'b111, 9'h000});
    check_bit("busy after disable", 1'b0, busy_o);
  endtask : s_all_and_disable

  // ********
  // run control
  // ********
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // runs far past the expected length of about 7000 cycles
  initial begin
    #500000;
    mismatches++;
    $display("watchdog expired");
    complete_run();
  end

  initial begin
    mismatches = 0;
    n_compared = 0;
    srst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    s_refused_write();
    s_write_poll();
    s_abort();
    s_erase_quiet();
    s_all_and_disable();
    complete_run();
  end
endmodule : sec_command_port_tb_top
